// ### src/i2c_flags_pkg.sv
// shared constants and types for the two-wire bus status and clock select block
package i2c_flags_pkg;
  localparam logic [15:0] ctrl_offset = 16'hffb0;
  localparam logic [15:0] prescaler_offset = 16'hffb2;
  localparam logic [15:0] slave_addr_offset = 16'hffb4;
  localparam logic [15:0] status_offset = 16'hffb6;
  localparam logic [15:0] tx_data_offset = 16'hffb8;

  localparam logic [7:0] prescaler_reset = 8'h00;
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] slave_addr_reset = 8'h00;
  localparam logic [7:0] tx_data_reset = 8'h00;
  localparam logic [7:0] prescaler_wr_mask = 8'h0f;

  // control register fields
  localparam int ctrl_bus_enable_bit = 7;
  localparam int ctrl_comm_release_bit = 6;
  localparam int ctrl_wait_release_bit = 5;
  localparam int ctrl_start_trigger_bit = 1;

  // prescaler fields
  localparam int clock_line_level_bit = 5;
  localparam int data_line_level_bit = 4;
  localparam int high_speed_select_bit = 3;
  localparam int input_filter_enable_bit = 2;
  localparam int clock_select_hi_bit = 1;
  localparam int clock_select_lo_bit = 0;

  // status fields
  localparam int extended_code_bit = 5;
  localparam int address_match_bit = 4;
  localparam int transmit_state_bit = 3;
  localparam int ack_detected_bit = 2;
  localparam int start_detected_bit = 1;
  localparam int stop_detected_bit = 0;

  // transfer clock divisors
  localparam logic [7:0] div_normal_0 = 8'd44;
  localparam logic [7:0] div_normal_1 = 8'd86;
  localparam logic [7:0] div_normal_2 = 8'd172;
  localparam logic [7:0] div_normal_timer = 8'd66;
  localparam logic [7:0] div_fast_0 = 8'd24;
  localparam logic [7:0] div_fast_2 = 8'd48;
  localparam logic [7:0] div_fast_timer = 8'd18;

  localparam logic [3:0] address_clock = 4'd8;
  localparam logic [3:0] ack_clock = 4'd9;
  localparam logic [3:0] ext_code_low = 4'h0;
  localparam logic [3:0] ext_code_high = 4'hf;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic clock_line_pin;
    logic data_line_pin;
  } bus_lines_t;
endpackage

// ### src/i2c_status_flags_and_clock_select.sv
// status flags, line level reporting and transfer clock prescaler of the two-wire bus
//
// Contract
// - extended code flag set at eighth clock rise
// - extended code cleared start/stop/release/disable/reset
// - address match flag set at eighth rise
// - address match cleared start/stop/release/disable/reset
// - transmit state on master start or read bit
// - transmit drives data latch, receive releases line
// - wait release at ninth clock ends transmit
// - acknowledge flag set on low ninth rise
// - acknowledge cleared stop/next byte/release/disable/reset
// - start flag set on start, address period
// - start flag cleared stop/next byte/release/disable/reset
// - stop flag set on stop detection
// - stop flag cleared at first address clock/disable/reset
// - prescaler bit 5 shows clock line level
// - prescaler bit 4 shows data line level
// - bits 4,5 read-only; bits 6,7 zero
// - normal mode divisors 44, 86, 172, timer/66
// - high-speed divisors 24, 48, timer/18
// - filter bit switches input filter only
// - status register read-only, reset to zero
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module i2c_status_flags_and_clock_select #(
  parameter int div_width = 8
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire i2c_flags_pkg::reg_req_t req_in,
  output logic [7:0] rdata_out,
  input wire i2c_flags_pkg::bus_lines_t lines_in,
  output logic clock_line_pin_out,
  output logic clock_line_pin_oe_out,
  output logic data_line_pin_out,
  output logic data_line_pin_oe_out,
  input wire logic timer_output_source_in,
  output logic transfer_clock_tick_out
);

  logic [7:0] ctrl_r;
  logic [3:0] prescaler_r;
  logic [7:0] slave_addr_r;
  logic [7:0] tx_data_r;
  logic ext_code_r, addr_match_r, tx_state_r, ack_det_r, start_flag_r, stop_flag_r;
  logic bus_enable_q;
  logic scl_s1_r, scl_s2_r, scl_s3_r, scl_f_r, scl_q_r;
  logic sda_s1_r, sda_s2_r, sda_s3_r, sda_f_r, sda_q_r;
  logic [3:0] bit_cnt_r;
  logic addr_byte_r;
  logic [7:0] shift_r;
  logic [7:0] out_latch_r;
  logic data_phase_r;
  logic wait_hold_r;
  logic ack_drive_r;
  logic [div_width-1:0] div_cnt_r;
  logic [div_width-1:0] divisor;
  logic use_timer;
  logic tick_src;
  logic transfer_clock_tick_r;
  logic [7:0] rdata_r;

  wire logic bus_enable = ctrl_r[i2c_flags_pkg::ctrl_bus_enable_bit];
  wire logic bus_disable_edge = bus_enable_q & ~bus_enable;
  wire logic wr_ctrl = req_in.wr && (req_in.addr == i2c_flags_pkg::ctrl_offset);
  wire logic comm_release_cmd = wr_ctrl && req_in.wdata[i2c_flags_pkg::ctrl_comm_release_bit];
  wire logic wait_release_cmd = wr_ctrl && req_in.wdata[i2c_flags_pkg::ctrl_wait_release_bit];
  wire logic start_cmd = wr_ctrl && bus_enable &&
    req_in.wdata[i2c_flags_pkg::ctrl_start_trigger_bit];
  wire logic high_speed_select = prescaler_r[i2c_flags_pkg::high_speed_select_bit];
  wire logic input_filter_enable = prescaler_r[i2c_flags_pkg::input_filter_enable_bit];
  wire logic clock_select_hi = prescaler_r[i2c_flags_pkg::clock_select_hi_bit];
  wire logic clock_select_lo = prescaler_r[i2c_flags_pkg::clock_select_lo_bit];

  // bus events, valid only while enabled
  wire logic scl_rise = bus_enable & scl_f_r & ~scl_q_r;
  wire logic scl_fall = bus_enable & ~scl_f_r & scl_q_r;
  wire logic start_det = bus_enable & scl_f_r & scl_q_r & sda_q_r & ~sda_f_r;
  wire logic stop_det = bus_enable & scl_f_r & scl_q_r & ~sda_q_r & sda_f_r;
  wire logic first_clock = scl_rise && (bit_cnt_r == i2c_flags_pkg::ack_clock);
  wire logic eighth_rise = scl_rise && (bit_cnt_r == (i2c_flags_pkg::address_clock - 4'd1));
  wire logic ninth_rise = scl_rise && (bit_cnt_r == i2c_flags_pkg::address_clock);
  wire logic [7:0] addr_rx = {shift_r[6:0], sda_f_r};
  wire logic transmit_state_flag = tx_state_r;
  wire logic address_match_flag = addr_match_r;
  wire logic extended_code_flag = ext_code_r;

  function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] off);
    reg_hit = (a == off);
  endfunction

  // register writes
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ctrl_r <= i2c_flags_pkg::ctrl_reset;
      prescaler_r <= i2c_flags_pkg::prescaler_reset[3:0];
      slave_addr_r <= i2c_flags_pkg::slave_addr_reset;
      tx_data_r <= i2c_flags_pkg::tx_data_reset;
    end
    else if (req_in.wr)
    begin
      // release and start commands are one-shot; they never stay stored
      if (reg_hit(req_in.addr, i2c_flags_pkg::ctrl_offset))
        ctrl_r <= req_in.wdata & 8'h9c;
      if (reg_hit(req_in.addr, i2c_flags_pkg::prescaler_offset))
        prescaler_r <= req_in.wdata[3:0];
      if (reg_hit(req_in.addr, i2c_flags_pkg::slave_addr_offset))
        slave_addr_r <= {req_in.wdata[7:1], 1'b0};
      if (reg_hit(req_in.addr, i2c_flags_pkg::tx_data_offset))
        tx_data_r <= req_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      bus_enable_q <= 1'b0;
    else
      bus_enable_q <= bus_enable;
  end

  // two-stage synchronisers, then optional two-sample filter
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
    end
    else
    begin
      scl_s1_r <= lines_in.clock_line_pin;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= lines_in.data_line_pin;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  // the filter adds latency to sampling only, never to the divider
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      if (!input_filter_enable || scl_s2_r == scl_s3_r)
        scl_f_r <= scl_s2_r;
      if (!input_filter_enable || sda_s2_r == sda_s3_r)
        sda_f_r <= sda_s2_r;
      scl_q_r <= scl_f_r;
      sda_q_r <= sda_f_r;
    end
  end

  // bit position and address byte tracking
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      bit_cnt_r <= 4'd0;
      addr_byte_r <= 1'b0;
      shift_r <= 8'h00;
      data_phase_r <= 1'b0;
    end
    else if (!bus_enable || stop_det || comm_release_cmd)
    begin
      bit_cnt_r <= 4'd0;
      addr_byte_r <= 1'b0;
      data_phase_r <= 1'b0;
    end
    else if (start_det)
    begin
      bit_cnt_r <= 4'd0;
      addr_byte_r <= 1'b1;
      data_phase_r <= 1'b0;
    end
    else
    begin
      if (scl_rise)
      begin
        shift_r <= addr_rx;
        if (bit_cnt_r == i2c_flags_pkg::ack_clock)
          bit_cnt_r <= 4'd1;
        else
          bit_cnt_r <= bit_cnt_r + 4'd1;
        if (first_clock)
          addr_byte_r <= 1'b0;
      end
      if (scl_fall && bit_cnt_r == i2c_flags_pkg::ack_clock && addr_byte_r)
        data_phase_r <= 1'b1;
    end
  end

  // extended code and address match
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ext_code_r <= 1'b0;
      addr_match_r <= 1'b0;
    end
    else
    begin
      if (start_det || stop_det || comm_release_cmd || bus_disable_edge)
      begin
        ext_code_r <= 1'b0;
        addr_match_r <= 1'b0;
      end
      if (eighth_rise && addr_byte_r)
      begin
        if (addr_rx[7:4] == i2c_flags_pkg::ext_code_low ||
            addr_rx[7:4] == i2c_flags_pkg::ext_code_high)
          ext_code_r <= 1'b1;
        if (addr_rx[7:1] == slave_addr_r[7:1])
          addr_match_r <= 1'b1;
      end
    end
  end

  // transmit state
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      tx_state_r <= 1'b0;
    else
    begin
      if (comm_release_cmd || bus_disable_edge || stop_det)
        tx_state_r <= 1'b0;
      if (wait_release_cmd && wait_hold_r && transmit_state_flag &&
          bit_cnt_r == i2c_flags_pkg::ack_clock)
        tx_state_r <= 1'b0;
      if (eighth_rise && addr_byte_r && addr_rx[7:1] == slave_addr_r[7:1])
        tx_state_r <= addr_rx[0];
      if (start_cmd)
        tx_state_r <= 1'b1;
    end
  end

  // acknowledge, start and stop flags; sets placed last so they win
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ack_det_r <= 1'b0;
      start_flag_r <= 1'b0;
      stop_flag_r <= 1'b0;
    end
    else
    begin
      if (stop_det || first_clock || comm_release_cmd || bus_disable_edge)
        ack_det_r <= 1'b0;
      if (stop_det || (first_clock && addr_byte_r) || comm_release_cmd || bus_disable_edge)
        start_flag_r <= 1'b0;
      if ((scl_rise && addr_byte_r && bit_cnt_r == 4'd0) || bus_disable_edge)
        stop_flag_r <= 1'b0;
      if (ninth_rise && !sda_f_r)
        ack_det_r <= 1'b1;
      if (start_det)
        start_flag_r <= 1'b1;
      if (stop_det)
        stop_flag_r <= 1'b1;
    end
  end

  // data line drive: latch shifted out at falling edges while transmitting
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      out_latch_r <= 8'hff;
      ack_drive_r <= 1'b0;
    end
    else
    begin
      if (!bus_enable || comm_release_cmd || stop_det || start_det)
      begin
        out_latch_r <= 8'hff;
        ack_drive_r <= 1'b0;
      end
      else if (scl_fall)
      begin
        if (bit_cnt_r == i2c_flags_pkg::ack_clock)
          out_latch_r <= tx_data_r;
        else if (bit_cnt_r != i2c_flags_pkg::address_clock)
          out_latch_r <= {out_latch_r[6:0], 1'b1};
        else
          out_latch_r <= 8'hff;
        // address acknowledge for a matched address or an extended code
        ack_drive_r <= (bit_cnt_r == i2c_flags_pkg::address_clock) && addr_byte_r &&
          (address_match_flag || extended_code_flag);
      end
    end
  end

  // clock line wait after the ninth clock when this end takes part
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      wait_hold_r <= 1'b0;
    else if (!bus_enable || comm_release_cmd || wait_release_cmd || stop_det)
      wait_hold_r <= 1'b0;
    else if (scl_fall && bit_cnt_r == i2c_flags_pkg::ack_clock &&
             (address_match_flag || extended_code_flag))
      wait_hold_r <= 1'b1;
  end

  wire logic tx_drive_low = transmit_state_flag && data_phase_r &&
    bit_cnt_r != i2c_flags_pkg::address_clock && !out_latch_r[7];

  // open-drain pins: drive only low, receive state leaves data released except for the address acknowledge
  assign clock_line_pin_out = 1'b0;
  assign clock_line_pin_oe_out = wait_hold_r;
  assign data_line_pin_out = 1'b0;
  assign data_line_pin_oe_out = ack_drive_r | tx_drive_low;

  // transfer clock divider
  always_comb
  begin
    use_timer = clock_select_hi & clock_select_lo;
    if (!high_speed_select)
    begin
      case ({clock_select_hi, clock_select_lo})
        2'b00: divisor = div_width'(i2c_flags_pkg::div_normal_0);
        2'b01: divisor = div_width'(i2c_flags_pkg::div_normal_1);
        2'b10: divisor = div_width'(i2c_flags_pkg::div_normal_2);
        default: divisor = div_width'(i2c_flags_pkg::div_normal_timer);
      endcase
    end
    else
    begin
      case ({clock_select_hi, clock_select_lo})
        2'b10: divisor = div_width'(i2c_flags_pkg::div_fast_2);
        2'b11: divisor = div_width'(i2c_flags_pkg::div_fast_timer);
        default: divisor = div_width'(i2c_flags_pkg::div_fast_0);
      endcase
    end
    tick_src = use_timer ? timer_output_source_in : 1'b1;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      div_cnt_r <= '0;
      transfer_clock_tick_r <= 1'b0;
    end
    else if (!bus_enable)
    begin
      div_cnt_r <= '0;
      transfer_clock_tick_r <= 1'b0;
    end
    else
    begin
      transfer_clock_tick_r <= 1'b0;
      if (tick_src)
      begin
        if (div_cnt_r >= divisor - div_width'(1))
        begin
          div_cnt_r <= '0;
          transfer_clock_tick_r <= 1'b1;
        end
        else
          div_cnt_r <= div_cnt_r + div_width'(1);
      end
    end
  end

  assign transfer_clock_tick_out = transfer_clock_tick_r;

  // read port, data one cycle after the strobe
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_r <= 8'h00;
    else if (req_in.rd)
    begin
      if (reg_hit(req_in.addr, i2c_flags_pkg::prescaler_offset))
        rdata_r <= {2'b00, bus_enable & scl_f_r, bus_enable & sda_f_r, prescaler_r};
      else if (reg_hit(req_in.addr, i2c_flags_pkg::status_offset))
        rdata_r <= {2'b00, ext_code_r, addr_match_r, tx_state_r, ack_det_r, start_flag_r,
          stop_flag_r};
      else if (reg_hit(req_in.addr, i2c_flags_pkg::ctrl_offset))
        rdata_r <= ctrl_r;
      else if (reg_hit(req_in.addr, i2c_flags_pkg::slave_addr_offset))
        rdata_r <= slave_addr_r;
      else if (reg_hit(req_in.addr, i2c_flags_pkg::tx_data_offset))
        rdata_r <= shift_r;
      else
        rdata_r <= 8'h00;
    end
    else
      rdata_r <= 8'h00;
  end

  assign rdata_out = rdata_r;

endmodule

`default_nettype wire

// ### verif/i2c_flags_monitor.sv
// checker for the status flags and clock select block
`timescale 1ns/100ps
`default_nettype none
module i2c_flags_monitor (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire i2c_flags_pkg::reg_req_t req_in,
  input wire logic [7:0] rdata_out,
  input wire i2c_flags_pkg::bus_lines_t lines_in,
  input wire logic clock_line_pin_out,
  input wire logic clock_line_pin_oe_out,
  input wire logic data_line_pin_out,
  input wire logic data_line_pin_oe_out,
  input wire logic timer_output_source_in,
  input wire logic transfer_clock_tick_out
);
  logic en_r;
  logic [3:0] presc_r;
  logic [3:0] hi_cnt_r;
  logic [7:0] gap_r;
  logic gap_ok_r;
  logic wr_ctrl;
  logic wr_presc;
  assign wr_ctrl = req_in.wr && req_in.addr == i2c_flags_pkg::ctrl_offset;
  assign wr_presc = req_in.wr && req_in.addr == i2c_flags_pkg::prescaler_offset;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      en_r <= 1'b0;
    else if (wr_ctrl)
      en_r <= req_in.wdata[7];
  end
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      presc_r <= 4'h0;
    else if (wr_presc)
      presc_r <= req_in.wdata[3:0];
  end
  // both lines idle high while enabled, saturating
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      hi_cnt_r <= 4'h0;
    else if (!en_r || !lines_in.clock_line_pin || !lines_in.data_line_pin)
      hi_cnt_r <= 4'h0;
    else if (hi_cnt_r != 4'hf)
      hi_cnt_r <= hi_cnt_r + 4'h1;
  end
  // first period after a setting change is partial, so it is skipped
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      gap_r <= 8'h00;
    else if (transfer_clock_tick_out)
      gap_r <= 8'h00;
    else if (gap_r != 8'hff)
      gap_r <= gap_r + 8'h01;
  end
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      gap_ok_r <= 1'b0;
    else if (wr_ctrl || wr_presc)
      gap_ok_r <= 1'b0;
    else if (transfer_clock_tick_out)
      gap_ok_r <= 1'b1;
  end
  sequence rd_presc_s;
    req_in.rd && req_in.addr == i2c_flags_pkg::prescaler_offset;
  endsequence
  sequence rd_status_s;
    req_in.rd && req_in.addr == i2c_flags_pkg::status_offset;
  endsequence
  presc_top_zero_a: assert property (rd_presc_s |=> rdata_out[7:6] == 2'b00)
    else $error("prescaler upper bits read nonzero");
  level_off_zero_a: assert property ((!en_r && !$past(en_r)) ##0 rd_presc_s |=>
    rdata_out[5:4] == 2'b00)
    else $error("line levels shown while bus disabled");
  level_high_a: assert property ((en_r && hi_cnt_r >= 4'd6) ##0 rd_presc_s |=>
    rdata_out[5:4] == 2'b11)
    else $error("high lines not shown as high");
  status_top_zero_a: assert property (rd_status_s |=> rdata_out[7:6] == 2'b00)
    else $error("status upper bits read nonzero");
  open_drain_low_a: assert property (!clock_line_pin_out && !data_line_pin_out)
    else $error("pin output value not low");
  tick_single_a: assert property (transfer_clock_tick_out |=> !transfer_clock_tick_out)
    else $error("transfer tick longer than one cycle");
  normal_gap_a: assert property (transfer_clock_tick_out && gap_ok_r && !presc_r[3] &&
    presc_r[1:0] != 2'b11 |-> gap_r == (presc_r[1:0] == 2'b00 ? 8'd43 :
    presc_r[1:0] == 2'b01 ? 8'd85 : 8'd171))
    else $error("normal mode tick spacing wrong");
  fast_gap_a: assert property (transfer_clock_tick_out && gap_ok_r && presc_r[3] &&
    presc_r[1:0] != 2'b11 |-> gap_r == (presc_r[1] ? 8'd47 : 8'd23))
    else $error("high speed tick spacing wrong");
  release_frees_a: assert property (wr_ctrl && (req_in.wdata[5] || req_in.wdata[6] ||
    !req_in.wdata[7]) |-> ##[1:3] !clock_line_pin_oe_out && !data_line_pin_oe_out)
    else $error("lines still pulled after release");
endmodule
bind i2c_status_flags_and_clock_select i2c_flags_monitor mon (.clk_in(clk_in),
  .resetn_in(resetn_in), .req_in(req_in), .rdata_out(rdata_out), .lines_in(lines_in),
  .clock_line_pin_out(clock_line_pin_out), .clock_line_pin_oe_out(clock_line_pin_oe_out),
  .data_line_pin_out(data_line_pin_out), .data_line_pin_oe_out(data_line_pin_oe_out),
  .timer_output_source_in(timer_output_source_in),
  .transfer_clock_tick_out(transfer_clock_tick_out));
`default_nettype wire

// ### verif/i2c_bus_master_model.sv
// bus master model pulling the two wires through open drain enables
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_master_model #(
  parameter int half_cycles = 10
) (
  input wire logic clk_in,
  input wire logic clock_wire_in,
  output logic clock_pull_out,
  output logic data_pull_out
);
  initial
  begin
    clock_pull_out = 1'b0;
    data_pull_out = 1'b0;
  end
  task automatic half();
    repeat (half_cycles) @(posedge clk_in);
  endtask
  // a slave may stretch the low phase, so wait for the wire itself
  task automatic clock_high();
    int n;
    clock_pull_out <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    while (clock_wire_in !== 1'b1 && n < 1000);
    half();
  endtask
  task automatic clock_low();
    clock_pull_out <= 1'b1;
    half();
  endtask
  task automatic bit_out(input logic b);
    data_pull_out <= !b;
    half();
    clock_high();
    clock_low();
  endtask
  task automatic start();
    data_pull_out <= 1'b1;
    half();
    clock_low();
  endtask
  task automatic stop();
    data_pull_out <= 1'b1;
    half();
    clock_high();
    data_pull_out <= 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

// ### verif/i2c_status_flags_and_clock_select_tb.sv
// self-checking bench for the status flags and clock select block
`timescale 1ns/100ps
`default_nettype none
module i2c_status_flags_and_clock_select_tb;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  i2c_flags_pkg::reg_req_t req = '0;
  logic [7:0] rdata;
  i2c_flags_pkg::bus_lines_t lines;
  logic scl_oe;
  logic sda_oe;
  logic m_scl;
  logic m_sda;
  logic timer = 1'b0;
  logic tick;
  int failures = 0;
  int tests_run = 0;
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) timer <= ~timer;
  // pulled-up wires: low when any party pulls
  assign lines = {~(m_scl | scl_oe), ~(m_sda | sda_oe)};
  i2c_status_flags_and_clock_select DUT (.clk_in(clk_in), .resetn_in(resetn_in),
    .req_in(req), .rdata_out(rdata), .lines_in(lines), .clock_line_pin_out(),
    .clock_line_pin_oe_out(scl_oe), .data_line_pin_out(), .data_line_pin_oe_out(sda_oe),
    .timer_output_source_in(timer), .transfer_clock_tick_out(tick));
  i2c_bus_master_model m (.clk_in(clk_in), .clock_wire_in(lines.clock_line_pin),
    .clock_pull_out(m_scl), .data_pull_out(m_sda));
  task automatic stop_test();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic ctl(input logic [7:0] d);
    wr(i2c_flags_pkg::ctrl_offset, d);
  endtask
  task automatic st(input logic [7:0] exp);
    rd(i2c_flags_pkg::status_offset, exp);
  endtask
  task automatic pr(input logic [7:0] exp);
    rd(i2c_flags_pkg::prescaler_offset, exp);
  endtask
  task automatic send_bits(input logic [7:0] b, input int from);
    for (int i = from; i >= 0; i--)
      m.bit_out(b[i]);
  endtask
  task automatic reset_check();
    pr(8'h00);
    st(8'h00);
    wr(i2c_flags_pkg::status_offset, 8'hff);
    st(8'h00);
    rd(16'hffba, 8'h00);
  endtask
  task automatic presc_access();
    wr(i2c_flags_pkg::prescaler_offset, 8'hff);
    pr(8'h0f);
    ctl(8'h80);
    repeat (8) @(posedge clk_in);
    pr(8'h3f);
    wr(i2c_flags_pkg::slave_addr_offset, 8'ha4);
  endtask
  task automatic match_tx();
    m.start();
    pr(8'h0f);
    st(8'h02);
    send_bits(8'ha5, 7);
    st(8'h1a);
    m.bit_out(1'b1);
    st(8'h1e);
    pr(8'h0f);
    ctl(8'ha0);
    st(8'h16);
    // released data line needs the synchroniser and filter to settle
    repeat (4) @(posedge clk_in);
    pr(8'h1f);
    m.bit_out(1'b1);
    st(8'h10);
    m.stop();
    st(8'h01);
  endtask
  task automatic ext_release();
    m.start();
    st(8'h03);
    m.bit_out(1'b1);
    st(8'h02);
    send_bits(8'h70, 6);
    st(8'h22);
    m.bit_out(1'b1);
    st(8'h26);
    ctl(8'hc0);
    st(8'h00);
    m.stop();
    st(8'h01);
  endtask
  task automatic no_match();
    m.start();
    send_bits(8'h12, 7);
    st(8'h02);
    m.bit_out(1'b1);
    st(8'h02);
    m.stop();
    st(8'h01);
    ctl(8'h82);
    st(8'h09);
    ctl(8'h00);
    st(8'h00);
    pr(8'h0f);
  endtask
  task automatic gap(output int n);
    n = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    while (tick !== 1'b1 && n < 400);
  endtask
  // timer input pulses every second cycle, so timer modes double the count
  task automatic divider();
    logic [7:0] sel [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09, 8'h0a, 8'h0b,
      8'h0c, 8'h04};
    logic [7:0] per [10] = '{8'd44, 8'd86, 8'd172, 8'd132, 8'd24, 8'd24, 8'd48, 8'd36,
      8'd24, 8'd44};
    int n;
    for (int i = 0; i < 10; i++)
    begin
      ctl(8'h00);
      wr(i2c_flags_pkg::prescaler_offset, sel[i]);
      ctl(8'h80);
      gap(n);
      gap(n);
      chk(8'(n), per[i]);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    reset_check();
    presc_access();
    match_tx();
    ext_release();
    no_match();
    divider();
    stop_test();
  end
  initial
  begin
    #100000;
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
